/* File: rtl/gpioa_cfg.svh */
`ifndef GPIOA_CFG_SVH
`define GPIOA_CFG_SVH

// ----------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------
`define GPIOA_OFS_PORT 6'h00
`define GPIOA_OFS_DIR 6'h04
`define GPIOA_OFS_ANA 6'h08
`define GPIOA_OFS_PUEN 6'h0C
`define GPIOA_OFS_CIE 6'h10
`define GPIOA_OFS_STEER 6'h14
`define GPIOA_OFS_OPT 6'h18
`define GPIOA_OFS_BITMOD 6'h1C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPIOA_RST_DIR 8'hFF
`define GPIOA_RST_LATCH 8'h00
`define GPIOA_RST_ANA 4'hF
`define GPIOA_RST_PUEN 8'h2F
`define GPIOA_RST_CIE 8'h00
`define GPIOA_RST_STEER 1'b0
`define GPIOA_RST_OPT_PU 1'b1

// ----------------------------------------
// Pin masks and field positions
// ----------------------------------------
`define GPIOA_DIR_FIXED 8'h20
`define GPIOA_PU_MASK 8'h2F
`define GPIOA_PU_SW 8'h0F
`define GPIOA_OD_MASK 8'h90
`define GPIOA_PP_MASK 8'h4F
`define GPIOA_BIT_RESET_PIN 5
`define GPIOA_BIT_SYNC_PIN 1
`define GPIOA_BIT_OPT_PU 7

`endif

/* File: rtl/gpioa_pkg.sv */
package gpioa_pkg;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    GPIOA_BUS_IDLE = 2'b01,
    GPIOA_BUS_ACK = 2'b10
  } gpioa_bus_t;

  typedef logic [7:0] gpioa_byte_t;

endpackage

/* File: rtl/gpioa_chg_if.sv */
`timescale 1ns/1ps

// Levels and enables in, per-pin change events out
interface gpioa_chg_if;
  logic [7:0] level;
  logic [7:0] enable;
  logic [7:0] event_pulse;
  modport det (input level, input enable, output event_pulse);
  modport core (output level, output enable, input event_pulse);
endinterface

/* File: rtl/gpioa_sync.sv */
`timescale 1ns/1ps

module gpioa_sync #(
  parameter int W = 9
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // Two-stage synchroniser per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/gpioa_chg.sv */
`timescale 1ns/1ps

module gpioa_chg
  import gpioa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  gpioa_chg_if.det chg
);
  gpioa_byte_t prev;
  gpioa_byte_t ev;

  // Either edge on an enabled pin gives a one-cycle event
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          prev[i] <= 1'b0;
          ev[i] <= 1'b0;
        end else begin
          prev[i] <= chg.level[i];
          ev[i] <= chg.enable[i] & (chg.level[i] ^ prev[i]);
        end
      end
    end
  endgenerate

  assign chg.event_pulse = ev;

  ev_enabled_only_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ev & ~$past(chg.enable)) == 8'h00)
    else $error("change event on a pin whose enable was clear");

  ev_on_edge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ev == ($past(chg.enable) & ($past(chg.level) ^ $past(prev))))
    else $error("change event does not match the pin edge");
endmodule

/* File: rtl/gpioa_top.sv */
`timescale 1ns/1ps
`include "gpioa_cfg.svh"

// Notes on behaviour
// - Direction bit one turns the pin driver off, making it an input.
// - Direction bit zero turns the driver on for push-pull pins, and for open-drain pins while they drive low.
// - Pin A5 is input only; its direction bit always reads one.
// - Port reads return pin levels; port writes go to the output latch.
// - Bit-modify writes are read-modify-write; untouched bits take the sampled pin levels.
// - Direction bits keep steering drivers while a pin is analog.
// - An analog-selected pin reads zero on every digital read.
// - A pin drives latch or alternate output only with direction cleared.
// - Each of the eight pins has its own change-interrupt enable bit.
// - Reset leaves change interrupts disabled on all pins.
// - Weak pull-ups exist only on A3 to A0 and A5.
// - A3 to A0 pull-ups are off for outputs, alternate functions, or global control set.
// - A5 pull-up follows the external reset pin configuration only.
// - Analog selection does not stop a pin driving digitally.
// - Analog select bits reset to analog; software clears them for digital.
// - Steering bit one puts sync clock on pin B5, zero on A1.
// - Steering changes no direction bit; only the selected pin is overridden.
// - Eight pins: five push-pull, two open-drain, one open-drain input only.
// - An enabled peripheral takes the pin away from general purpose use.
// - A3 to A0 pull-up on needs global allow, input, enable bit, and not analog.
// - Several enabled outputs on one pin: the highest priority wins.

module gpioa_top
  import gpioa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] pin_a_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe_out,
  output logic [7:0] pullup_on_out,
  input wire logic reset_pin_config_in,
  input wire logic [7:0] alt_enable_in,
  input wire logic [7:0] alt_data_in,
  input wire logic sync_clk_enable_in,
  input wire logic sync_clk_data_in,
  output logic sync_clk_level_out,
  input wire logic pin_b_five_in,
  output logic pin_b_five_alt_out,
  output logic pin_b_five_data_out,
  output logic [7:0] pin_level_out,
  output logic [3:0] analog_select_out,
  output logic [7:0] change_event_out
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  gpioa_byte_t port_a_pin_data;
  gpioa_byte_t pin_direction_a;
  logic [3:0] analog_select_a;
  gpioa_byte_t pullup_enable_a;
  gpioa_byte_t change_interrupt_enable;
  logic sync_clock_pin_select;
  logic global_pullup_control;
  logic external_reset_pin;
  gpioa_bus_t bus_state;
  gpioa_bus_t next_bus_state;
  logic [31:0] next_readdata;

  // ----------------------------------------
  // Pin sampling and derived terms
  // ----------------------------------------
  logic [8:0] pin_sync;
  gpioa_byte_t pin_read;
  gpioa_byte_t ana_wide;
  gpioa_byte_t dir_eff;
  gpioa_byte_t alt_use;
  gpioa_byte_t alt_val;
  gpioa_byte_t drive_val;
  gpioa_byte_t next_pin_out;
  gpioa_byte_t next_pin_oe;
  gpioa_byte_t next_pullup;
  logic sync_on_a1;
  logic acc;
  logic wr_port;
  logic wr_bitmod;
  logic wr_reg;

  // Pins and B5 are asynchronous to clk_in
  gpioa_sync #(
    .W(9)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in({pin_b_five_in, pin_a_in}),
    .sync_out(pin_sync)
  );

  assign ana_wide = {4'h0, analog_select_a};
  assign pin_read = pin_sync[7:0] & ~ana_wide;
  assign dir_eff = pin_direction_a | `GPIOA_DIR_FIXED;

  // ----------------------------------------
  // Output steering
  // ----------------------------------------
  // Sync clock takes A1 only while it is steered there; B5 is handled by port B
  assign sync_on_a1 = sync_clk_enable_in & ~sync_clock_pin_select;

  // An enabled peripheral outranks the latch on its pin
  always_comb begin
    alt_use = alt_enable_in;
    alt_val = alt_data_in;
    if (sync_on_a1) begin
      alt_use[`GPIOA_BIT_SYNC_PIN] = 1'b1;
      alt_val[`GPIOA_BIT_SYNC_PIN] = sync_clk_data_in;
    end
    drive_val = (alt_use & alt_val) | (~alt_use & port_a_pin_data);
  end

  // Driver enables come from direction and, on open-drain pins, the drive value, never from analog select
  always_comb begin
    next_pin_out = drive_val & `GPIOA_PP_MASK;
    next_pin_oe = ~dir_eff & (`GPIOA_PP_MASK | (`GPIOA_OD_MASK & ~drive_val));
  end

  // A3 to A0 pull-ups gated by global control, input mode, enable bit, analog and alternate use; A5 follows the reset pin
  always_comb begin
    next_pullup = ~{8{global_pullup_control}} & dir_eff & pullup_enable_a & ~ana_wide & ~alt_use
      & `GPIOA_PU_SW;
    next_pullup[`GPIOA_BIT_RESET_PIN] = external_reset_pin;
  end

  // Registered pin side: one cycle behind the registers, but glitch free
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_a_out <= 8'h00;
      pin_a_oe_out <= 8'h00;
      pullup_on_out <= 8'h00;
    end else begin
      pin_a_out <= next_pin_out;
      pin_a_oe_out <= next_pin_oe;
      pullup_on_out <= next_pullup;
    end
  end

  // Peripheral-facing levels and B5 override
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_level_out <= 8'h00;
      sync_clk_level_out <= 1'b0;
      pin_b_five_alt_out <= 1'b0;
      pin_b_five_data_out <= 1'b0;
    end else begin
      pin_level_out <= pin_read;
      sync_clk_level_out <= sync_clock_pin_select ? pin_sync[8] : pin_read[`GPIOA_BIT_SYNC_PIN];
      pin_b_five_alt_out <= sync_clk_enable_in & sync_clock_pin_select;
      pin_b_five_data_out <= sync_clk_data_in;
    end
  end

  assign analog_select_out = analog_select_a;

  // ----------------------------------------
  // Change detection
  // ----------------------------------------
  gpioa_chg_if chg_bus ();

  // Analog pins read zero, so they never raise change events
  assign chg_bus.level = pin_read;
  assign chg_bus.enable = change_interrupt_enable & ~ana_wide;
  assign change_event_out = chg_bus.event_pulse;

  gpioa_chg u_chg (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .chg(chg_bus)
  );

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Every access waits exactly one cycle; writes land on the accepting edge
  assign acc = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = acc & (bus_state != GPIOA_BUS_ACK);
  assign wr_reg = avs_write_in & (bus_state == GPIOA_BUS_ACK) & avs_byteenable_in[0];
  assign wr_port = wr_reg & (avs_address_in == `GPIOA_OFS_PORT);
  assign wr_bitmod = wr_reg & avs_byteenable_in[1] & (avs_address_in == `GPIOA_OFS_BITMOD);

  // Bus state sequencing
  always_comb begin
    case (bus_state)
      GPIOA_BUS_IDLE: next_bus_state = acc ? GPIOA_BUS_ACK : GPIOA_BUS_IDLE;
      GPIOA_BUS_ACK: next_bus_state = GPIOA_BUS_IDLE;
      default: next_bus_state = GPIOA_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bus_state <= GPIOA_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address_in)
      `GPIOA_OFS_PORT: next_readdata = {24'h000000, pin_read};
      `GPIOA_OFS_DIR: next_readdata = {24'h000000, dir_eff};
      `GPIOA_OFS_ANA: next_readdata = {24'h000000, ana_wide};
      `GPIOA_OFS_PUEN: next_readdata = {24'h000000, pullup_enable_a & `GPIOA_PU_MASK};
      `GPIOA_OFS_CIE: next_readdata = {24'h000000, change_interrupt_enable};
      `GPIOA_OFS_STEER: next_readdata = {31'h00000000, sync_clock_pin_select};
      `GPIOA_OFS_OPT: next_readdata = {24'h000000, global_pullup_control, 7'h00};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Read data captured on the first edge and held through the answer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && bus_state == GPIOA_BUS_IDLE) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Output latch: plain write, or bit modify built on sampled pin levels
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      port_a_pin_data <= `GPIOA_RST_LATCH;
    end else if (wr_port) begin
      port_a_pin_data <= avs_writedata_in[7:0];
    end else if (wr_bitmod) begin
      port_a_pin_data <= (pin_read & ~avs_writedata_in[7:0]) | (avs_writedata_in[15:8] & avs_writedata_in[7:0]);
    end
  end

  // Direction; bit five is stored but always reads and acts as input
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_direction_a <= `GPIOA_RST_DIR;
    end else if (wr_reg && avs_address_in == `GPIOA_OFS_DIR) begin
      pin_direction_a <= avs_writedata_in[7:0];
    end
  end

  // Analog select comes up analog; software must clear it
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      analog_select_a <= `GPIOA_RST_ANA;
    end else if (wr_reg && avs_address_in == `GPIOA_OFS_ANA) begin
      analog_select_a <= avs_writedata_in[3:0];
    end
  end

  // Pull-up enables: only implemented bits are kept
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pullup_enable_a <= `GPIOA_RST_PUEN;
    end else if (wr_reg && avs_address_in == `GPIOA_OFS_PUEN) begin
      pullup_enable_a <= avs_writedata_in[7:0] & `GPIOA_PU_MASK;
    end
  end

  // Change enables are clear after reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      change_interrupt_enable <= `GPIOA_RST_CIE;
    end else if (wr_reg && avs_address_in == `GPIOA_OFS_CIE) begin
      change_interrupt_enable <= avs_writedata_in[7:0];
    end
  end

  // Steering and global pull-up control
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sync_clock_pin_select <= `GPIOA_RST_STEER;
      global_pullup_control <= `GPIOA_RST_OPT_PU;
    end else begin
      if (wr_reg && avs_address_in == `GPIOA_OFS_STEER) begin
        sync_clock_pin_select <= avs_writedata_in[0];
      end
      if (wr_reg && avs_address_in == `GPIOA_OFS_OPT) begin
        global_pullup_control <= avs_writedata_in[`GPIOA_BIT_OPT_PU];
      end
    end
  end

  // Reset-pin configuration is a strap, caught while reset is held
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      external_reset_pin <= reset_pin_config_in;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  dir_five_fixed_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    dir_eff[`GPIOA_BIT_RESET_PIN] && !pin_a_oe_out[`GPIOA_BIT_RESET_PIN])
    else $error("pin A5 direction or driver not input only");

  input_driver_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> ((pin_a_oe_out & $past(dir_eff)) == 8'h00))
    else $error("driver enabled on a pin set as input");

  output_driver_on_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> ((~$past(dir_eff) & `GPIOA_PP_MASK & ~pin_a_oe_out) == 8'h00))
    else $error("push-pull output pin not driven");

  open_drain_low_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pin_a_out & `GPIOA_OD_MASK) == 8'h00)
    else $error("open-drain pin driven high");

  analog_reads_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pin_read & ana_wide) == 8'h00 && (chg_bus.enable & ana_wide) == 8'h00)
    else $error("analog pin seen as digital");

  pullup_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> ((pullup_on_out & 8'hD0) == 8'h00)
      && (!$past(global_pullup_control) || pullup_on_out[3:0] == 4'h0)
      && ((pullup_on_out[3:0] & ~$past(dir_eff[3:0])) == 4'h0))
    else $error("weak pull-up on where it must be off");

  // The registered pull-up still shows its reset value at the first edge after release
  reset_pin_pullup_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> pullup_on_out[`GPIOA_BIT_RESET_PIN] == $past(external_reset_pin))
    else $error("A5 pull-up does not follow reset pin configuration");

  bit_modify_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_bitmod |=> port_a_pin_data == (($past(pin_read) & ~$past(avs_writedata_in[7:0]))
      | ($past(avs_writedata_in[15:8]) & $past(avs_writedata_in[7:0]))))
    else $error("bit modify did not merge sampled pin levels");

  bus_one_wait_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (acc && bus_state == GPIOA_BUS_IDLE) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("access not answered after exactly one wait cycle");

  // A direction write in the same cycle is software's doing, not the steering's
  steer_b_five_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sync_clk_enable_in && sync_clock_pin_select && !(wr_reg && avs_address_in == `GPIOA_OFS_DIR))
      |-> ##1 (pin_b_five_alt_out && pin_direction_a == $past(pin_direction_a)))
    else $error("sync clock not moved to pin B5 cleanly");
endmodule

/* File: sim/gpioa_pin_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Pad model for the eight port A wires
// ----------------------------------------
module gpioa_pin_model (
  input wire logic clk_in,
  input wire logic [7:0] pin_a_out_in,
  input wire logic [7:0] pin_a_oe_in,
  input wire logic [7:0] pullup_on_in,
  input wire logic [7:0] ext_drive_in,
  input wire logic [7:0] ext_value_in,
  output logic [7:0] pin_a_level_out
);
  logic [7:0] float_pat = 8'hA5;

  // Undriven wires wander each cycle, so a lost driver never reads as a clean level
  always @(posedge clk_in) begin
    float_pat <= ~float_pat;
  end

  // Device driver first, then the outside party, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_a_oe_in[i]) begin
        pin_a_level_out[i] = pin_a_out_in[i];
      end else if (ext_drive_in[i]) begin
        pin_a_level_out[i] = ext_value_in[i];
      end else if (pullup_on_in[i]) begin
        pin_a_level_out[i] = 1'b1;
      end else begin
        pin_a_level_out[i] = float_pat[i];
      end
    end
  end
endmodule

/* File: sim/gpioa_tb.sv */
`timescale 1ns/1ps
`include "gpioa_cfg.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module gpioa_tb;
  import gpioa_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [5:0] address = 6'h00;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq;
  logic [7:0] pin_out, pin_oe, pu_on, pin_lvl, pin_rd, events, seen;
  logic [7:0] alt_en = 8'h00;
  logic [7:0] alt_dat = 8'h00;
  logic [7:0] ext_val = 8'h30;
  logic sclk_en = 1'b0;
  logic sclk_dat = 1'b0;
  logic strap = 1'b1;
  logic b5_pin = 1'b0;
  logic sclk_lvl, b5_alt, b5_dat;
  logic [3:0] ana, cnt;
  int n_mismatch = 0;
  int n_checks = 0;

  always #50 clk_in = ~clk_in;

  gpioa_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(address), .avs_read_in(rd_req),
    .avs_write_in(wr_req), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .pin_a_in(pin_rd), .pin_a_out(pin_out), .pin_a_oe_out(pin_oe),
    .pullup_on_out(pu_on), .reset_pin_config_in(strap), .alt_enable_in(alt_en), .alt_data_in(alt_dat),
    .sync_clk_enable_in(sclk_en), .sync_clk_data_in(sclk_dat), .sync_clk_level_out(sclk_lvl),
    .pin_b_five_in(b5_pin), .pin_b_five_alt_out(b5_alt), .pin_b_five_data_out(b5_dat),
    .pin_level_out(pin_lvl), .analog_select_out(ana), .change_event_out(events));

  gpioa_pin_model PADS (.clk_in(clk_in), .pin_a_out_in(pin_out), .pin_a_oe_in(pin_oe),
    .pullup_on_in(pu_on), .ext_drive_in(8'hFF), .ext_value_in(ext_val), .pin_a_level_out(pin_rd));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Waitrequest is read at the rising edge before its updates land; the edge that sees it low takes the access
  task automatic wait_ack();
    int i;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (waitreq !== 1'b0 && i < 20);
    if (waitreq !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  // An idle cycle after each access keeps a strobe from being set twice in one step
  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
    address <= a;
    wdata <= {16'h0000, d};
    wr_req <= 1'b1;
    wait_ack();
    wr_req <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic chk_reg(input string nm, input logic [5:0] a, input logic [7:0] exp);
    logic [31:0] d;
    address <= a;
    rd_req <= 1'b1;
    wait_ack();
    d = rdata;
    rd_req <= 1'b0;
    `CHK(nm, {24'h000000, exp}, d)
    @(posedge clk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Flip the outside levels, collect change events and count pin A0 pulses over eight cycles
  task automatic ev_run(input logic [7:0] v);
    seen = 8'h00;
    cnt = 4'h0;
    ext_val <= v;
    repeat (8) begin
      @(posedge clk_in);
      seen |= events;
      cnt += {3'b000, events[0]};
    end
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    idle(2);
    `CHK("oe", 8'h00, pin_oe)
    `CHK("pullup", 8'h20, pu_on)
    chk_reg("dir", `GPIOA_OFS_DIR, 8'hFF);
    chk_reg("ana", `GPIOA_OFS_ANA, 8'h0F);
    chk_reg("cie", `GPIOA_OFS_CIE, 8'h00);
    chk_reg("puen", `GPIOA_OFS_PUEN, 8'h2F);
    chk_reg("steer", `GPIOA_OFS_STEER, 8'h00);
    chk_reg("unmapped", 6'h20, 8'h00);
    $display("test reset done");
    bus_wr(`GPIOA_OFS_ANA, 16'h0000);
    bus_wr(`GPIOA_OFS_PORT, 16'h0055);
    bus_wr(`GPIOA_OFS_DIR, 16'h0000);
    idle(4);
    chk_reg("dir", `GPIOA_OFS_DIR, 8'h20);
    `CHK("oe", 8'hCF, pin_oe)
    `CHK("out", 8'h45, pin_out)
    chk_reg("port", `GPIOA_OFS_PORT, 8'h75);
    bus_wr(`GPIOA_OFS_ANA, 16'h000F);
    idle(4);
    `CHK("oe", 8'hCF, pin_oe)
    `CHK("out", 8'h45, pin_out)
    `CHK("ana", 4'hF, ana)
    `CHK("level", 8'h70, pin_lvl)
    chk_reg("port", `GPIOA_OFS_PORT, 8'h70);
    bus_wr(`GPIOA_OFS_DIR, 16'h00FF);
    bus_wr(`GPIOA_OFS_ANA, 16'h0000);
    ext_val <= 8'hA3;
    idle(3);
    `CHK("oe", 8'h00, pin_oe)
    $display("test direction done");
    bus_wr(`GPIOA_OFS_BITMOD, 16'h050F);
    bus_wr(`GPIOA_OFS_DIR, 16'h0000);
    idle(3);
    `CHK("out", 8'h05, pin_out)
    `CHK("oe", 8'h5F, pin_oe)
    alt_en <= 8'h01;
    idle(3);
    `CHK("out", 8'h04, pin_out)
    alt_en <= 8'h00;
    $display("test latch done");
    bus_wr(`GPIOA_OFS_DIR, 16'h00FF);
    bus_wr(`GPIOA_OFS_OPT, 16'h0000);
    bus_wr(`GPIOA_OFS_PUEN, 16'h00FF);
    idle(3);
    `CHK("pullup", 8'h2F, pu_on)
    chk_reg("puen", `GPIOA_OFS_PUEN, 8'h2F);
    bus_wr(`GPIOA_OFS_DIR, 16'h00FC);
    idle(3);
    `CHK("pullup", 8'h2C, pu_on)
    bus_wr(`GPIOA_OFS_ANA, 16'h0004);
    idle(3);
    `CHK("pullup", 8'h28, pu_on)
    alt_en <= 8'h08;
    idle(3);
    `CHK("pullup", 8'h20, pu_on)
    alt_en <= 8'h00;
    bus_wr(`GPIOA_OFS_OPT, 16'h0080);
    idle(3);
    `CHK("pullup", 8'h20, pu_on)
    $display("test pullup done");
    sclk_en <= 1'b1;
    sclk_dat <= 1'b1;
    b5_pin <= 1'b1;
    bus_wr(`GPIOA_OFS_DIR, 16'h00FD);
    bus_wr(`GPIOA_OFS_STEER, 16'h0001);
    idle(3);
    `CHK("b5alt", 1'b1, b5_alt)
    `CHK("b5dat", 1'b1, b5_dat)
    `CHK("sclk", 1'b1, sclk_lvl)
    `CHK("a1out", 1'b0, pin_out[1])
    chk_reg("dir", `GPIOA_OFS_DIR, 8'hFD);
    b5_pin <= 1'b0;
    bus_wr(`GPIOA_OFS_STEER, 16'h0000);
    idle(3);
    `CHK("b5alt", 1'b0, b5_alt)
    `CHK("a1out", 1'b1, pin_out[1])
    chk_reg("dir", `GPIOA_OFS_DIR, 8'hFD);
    `CHK("sclk", 1'b1, sclk_lvl)
    sclk_en <= 1'b0;
    $display("test steering done");
    bus_wr(`GPIOA_OFS_DIR, 16'h00FF);
    bus_wr(`GPIOA_OFS_ANA, 16'h0000);
    bus_wr(`GPIOA_OFS_CIE, 16'h0001);
    ext_val <= 8'h00;
    idle(4);
    ev_run(8'h01);
    `CHK("events", 8'h01, seen)
    `CHK("pulses", 4'h1, cnt)
    bus_wr(`GPIOA_OFS_CIE, 16'h0002);
    ev_run(8'h00);
    `CHK("events", 8'h00, seen)
    bus_wr(`GPIOA_OFS_CIE, 16'h0001);
    bus_wr(`GPIOA_OFS_ANA, 16'h0001);
    ev_run(8'h01);
    `CHK("events", 8'h00, seen)
    $display("test change done");
    // Second reset with the strap low: A5 pull-up must drop and change enables clear
    strap <= 1'b0;
    rstn_in <= 1'b0;
    idle(4);
    rstn_in <= 1'b1;
    idle(2);
    `CHK("pullup", 8'h00, pu_on)
    chk_reg("cie", `GPIOA_OFS_CIE, 8'h00);
    $display("test strap done");
    print_verdict();
  end

  // Guard against a hung run
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    print_verdict();
  end
endmodule
